/* esti_phy_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Far-side model: frame results as the MAC datapath reports them
// ------------------------------------------------------------
module esti_phy_model
(
   input  wire logic        clk,      // System clock
   output logic             rx_done,  // Receive finished, pulse
   output logic      [10:0] rx_len,   // Received length in bytes
   output logic      [15:0] rx_type,  // Type/length field
   output logic      [2:0]  rx_err,   // Symbol, alignment, FCS errors
   output logic             rx_pause, // Pause frame
   output logic      [1:0]  rx_ok,    // Copied, address recognised
   output logic             tx_done,  // Transmit finished, pulse
   output logic      [1:0]  tx_bad,   // Retry limit, underrun
   output logic      [4:0]  tx_coll   // Collisions seen
);
   // Idle at time zero
   initial
   begin
      {rx_done, rx_len, rx_type, rx_err, rx_pause, rx_ok} = '0;
      {tx_done, tx_bad, tx_coll} = '0;
   end

   // One received frame; qualifiers scrambled once the pulse is over
   task automatic rx(input logic [10:0] l, input logic [15:0] t, input logic [2:0] e,
                     input logic p, input logic [1:0] k);
      @(posedge clk);
      {rx_done, rx_len, rx_type, rx_err, rx_pause, rx_ok} <= {1'b1, l, t, e, p, k};
      @(posedge clk);
      {rx_done, rx_len, rx_type, rx_err, rx_pause, rx_ok} <= {1'b0, ~l, ~t, ~e, ~p, ~k};
   endtask

   // One finished transmit attempt, same shape
   task automatic tx(input logic [1:0] b, input logic [4:0] c);
      @(posedge clk);
      {tx_done, tx_bad, tx_coll} <= {1'b1, b, c};
      @(posedge clk);
      {tx_done, tx_bad, tx_coll} <= {1'b0, ~b, ~c};
   endtask
endmodule

/* esti_pkg.sv */
package esti_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses on the APB)
   // ------------------------------------------------------------
   localparam logic [7:0] ESTI_OFS_NET_CONTROL  = 8'h00;  // Receive enable, statistics write enable
   localparam logic [7:0] ESTI_OFS_NET_CONFIG   = 8'h04;  // Long frame enable
   localparam logic [7:0] ESTI_OFS_TYPE_ID      = 8'h08;  // type_id_compare
   localparam logic [7:0] ESTI_OFS_USER_IO      = 8'h0c;  // user_io_control
   localparam logic [7:0] ESTI_OFS_PAUSE_RX     = 8'h10;  // pause_rx_count
   localparam logic [7:0] ESTI_OFS_TX_GOOD      = 8'h14;  // tx_good_count
   localparam logic [7:0] ESTI_OFS_ONE_COLL     = 8'h18;  // one_collision_count
   localparam logic [7:0] ESTI_OFS_SEVERAL_COLL = 8'h1c;  // several_collision_count
   localparam logic [7:0] ESTI_OFS_RX_GOOD      = 8'h20;  // rx_good_count

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ESTI_BIT_RX_ENABLE   = 2;  // Network control: receive enable
   localparam int ESTI_BIT_STATS_WR_EN = 7;  // Network control: statistics write enable
   localparam int ESTI_BIT_LONG_FRAME  = 8;  // Network config: accept up to 1536 bytes
   localparam int ESTI_BIT_RMII        = 0;  // User I/O: RMII mode select
   localparam int ESTI_BIT_CLK_GATE    = 1;  // User I/O: transceiver clock enable
   localparam int ESTI_TYPE_ID_W       = 16; // Width of the type compare value

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] ESTI_RST_NET_CONTROL = 32'h0000_0000;
   localparam logic [31:0] ESTI_RST_NET_CONFIG  = 32'h0000_0000;
   localparam logic [15:0] ESTI_RST_TYPE_ID     = 16'h0000;
   localparam logic [1:0]  ESTI_RST_USER_IO     = 2'h0;

   // ------------------------------------------------------------
   // Statistics counters
   // ------------------------------------------------------------
   localparam int ESTI_NUM_CNT      = 5;
   localparam int ESTI_CNT_PAUSE    = 0;
   localparam int ESTI_CNT_TX_GOOD  = 1;
   localparam int ESTI_CNT_ONE      = 2;
   localparam int ESTI_CNT_SEVERAL  = 3;
   localparam int ESTI_CNT_RX_GOOD  = 4;
   localparam int ESTI_CNT_MAX_W    = 24;
   localparam int ESTI_CNT_W [ESTI_NUM_CNT] = '{16, 24, 16, 16, 24};

   // ------------------------------------------------------------
   // Frame length and collision limits
   // ------------------------------------------------------------
   localparam logic [10:0] ESTI_LEN_MIN       = 11'd64;
   localparam logic [10:0] ESTI_LEN_MAX       = 11'd1518;
   localparam logic [10:0] ESTI_LEN_MAX_LONG  = 11'd1536;
   localparam logic [4:0]  ESTI_COLL_ONE      = 5'd1;
   localparam logic [4:0]  ESTI_COLL_SEV_MIN  = 5'd2;
   localparam logic [4:0]  ESTI_COLL_SEV_MAX  = 5'd15;

endpackage

/* esti_sat_counter.sv */
`timescale 1ns/1ps

// Saturating, clear-on-read statistics counter
module esti_sat_counter
#(
   parameter int W = 16                  // Counter width
)
(
   input  wire logic         clk,        // System clock
   input  wire logic         rst,        // Synchronous reset, active high
   input  wire logic         inc,        // Counted event, one-cycle pulse
   input  wire logic         clr,        // Clearing read
   input  wire logic         wr,         // Software write
   input  wire logic [W-1:0] wdata,      // Software write data
   output logic      [W-1:0] count       // Current count
);

   logic [W-1:0] count_q;                // Count register
   logic [W-1:0] count_d;                // Next count
   logic         full_w;                 // Count at all ones

   assign full_w = &count_q;
   assign count  = count_q;

   // ------------------------------------------------------------
   // Next count
   // ------------------------------------------------------------
   // Write first, then clear, then a saturating increment
   always_comb
   begin
      count_d = count_q;
      if (wr)
      begin
         count_d = wdata;
      end
      else if (clr)
      begin
         // An event in the clearing cycle survives as a count of one
         count_d = inc ? W'(1) : '0;
      end
      else if (inc && !full_w)
      begin
         count_d = count_q + W'(1);
      end
   end

   // Count register
   always_ff @(posedge clk)
   begin
      if (rst)
         count_q <= '0;
      else
         count_q <= count_d;
   end

endmodule

/* esti_top.sv */
`timescale 1ns/1ps

// Summary of operation
// - Compare stored type value with received type field
// - User I/O bit 0 selects RMII, else MII
// - User I/O bit 1 enables transceiver clock
// - Counters clear to zero when read; an event in the reading cycle leaves a count of one
// - Counters stick at all ones
// - Receive counters count only with receive enabled
// - Counter writes need control bit 7 set
// - 16-bit count of good pause frames
// - 24-bit count of good transmitted frames
// - 16-bit count of single-collision sent frames
// - 16-bit count of 2-15 collision sent frames
// - 24-bit count of good received copied frames
module esti_top
   import esti_pkg::*;
(
   input  wire logic        clk,            // System clock, 10 MHz
   input  wire logic        rst,            // Synchronous reset, active high
   input  wire logic        psel,           // APB select
   input  wire logic        penable,        // APB enable
   input  wire logic        pwrite,         // APB write
   input  wire logic [7:0]  paddr,          // APB byte address
   input  wire logic [31:0] pwdata,         // APB write data
   output logic             pready,         // APB ready
   output logic      [31:0] prdata,         // APB read data
   output logic             pslverr,        // APB error on unmapped address
   input  wire logic        rx_frame_done,  // Received frame finished, pulse
   input  wire logic [10:0] rx_frame_len,   // Received frame length in bytes
   input  wire logic [15:0] rx_type_len,    // Received type/length field
   input  wire logic        rx_fcs_err,     // Received frame has bad FCS
   input  wire logic        rx_align_err,   // Received frame has alignment error
   input  wire logic        rx_symbol_err,  // Received frame has symbol error
   input  wire logic        rx_is_pause,    // Received frame is a pause frame
   input  wire logic        rx_addr_match,  // Destination address recognised
   input  wire logic        rx_copied_ok,   // Frame copied to memory
   input  wire logic        tx_frame_done,  // Transmit attempt finished, pulse
   input  wire logic        tx_underrun,    // Transmit underrun happened
   input  wire logic        tx_retry_limit, // Retry limit exceeded
   input  wire logic [4:0]  tx_collisions,  // Collisions seen by this frame
   output logic             type_match,     // Type field matched, pulse
   output logic             rx_enable,      // Receive enable to the MAC
   output logic             long_frame_en,  // 1536-byte frames allowed
   output logic             rmii_mode,      // 1 = RMII, 0 = MII
   output logic             phy_clock_gate_on // Transceiver input clock enable
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [31:0] net_control_q;              // Network control register
   logic [31:0] net_config_q;               // Network configuration register
   logic [15:0] type_compare_value_q;       // Type compare value
   logic [1:0]  user_io_q;                  // User I/O control bits
   logic [31:0] prdata_q;                   // Captured read data
   logic        type_match_q;               // Type match pulse
   logic        setup_w;                    // APB setup phase
   logic        access_w;                   // APB access phase
   logic        rd_setup_w;                 // Read seen in setup phase
   logic        wr_access_w;                // Write taking effect
   logic        stats_wr_en_w;              // Statistics write enable
   logic        hit_w;                      // Address is mapped
   logic [31:0] rd_mux_w;                   // Read data selection
   logic        rx_len_ok_w;                // Length within limits
   logic        rx_good_w;                  // Good received frame
   logic        tx_ok_w;                    // Successful transmission
   logic [ESTI_NUM_CNT-1:0]   sel_w;        // Counter address decode
   logic [ESTI_NUM_CNT-1:0]   inc_w;        // Counter events
   logic [ESTI_NUM_CNT-1:0]   clr_w;        // Counter clears
   logic [ESTI_NUM_CNT-1:0]   cwr_w;        // Counter writes
   logic [ESTI_CNT_MAX_W-1:0] cnt_w [ESTI_NUM_CNT]; // Counter values, zero extended
   logic [ESTI_CNT_MAX_W-1:0] cnt_max_w [ESTI_NUM_CNT]; // All-ones per counter

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   assign setup_w      = psel && !penable;
   assign access_w     = psel && penable;
   assign rd_setup_w   = setup_w && !pwrite;
   assign wr_access_w  = access_w && pwrite;
   assign stats_wr_en_w = net_control_q[ESTI_BIT_STATS_WR_EN];

   assign sel_w[ESTI_CNT_PAUSE]   = (paddr == ESTI_OFS_PAUSE_RX);
   assign sel_w[ESTI_CNT_TX_GOOD] = (paddr == ESTI_OFS_TX_GOOD);
   assign sel_w[ESTI_CNT_ONE]     = (paddr == ESTI_OFS_ONE_COLL);
   assign sel_w[ESTI_CNT_SEVERAL] = (paddr == ESTI_OFS_SEVERAL_COLL);
   assign sel_w[ESTI_CNT_RX_GOOD] = (paddr == ESTI_OFS_RX_GOOD);

   assign hit_w = (|sel_w) || (paddr == ESTI_OFS_NET_CONTROL) ||
                  (paddr == ESTI_OFS_NET_CONFIG) || (paddr == ESTI_OFS_TYPE_ID) ||
                  (paddr == ESTI_OFS_USER_IO);

   // Zero wait states; error only for an unmapped address
   assign pready  = 1'b1;
   assign pslverr = access_w && !hit_w;
   assign prdata  = prdata_q;

   // Read selection; unused bits read as zero except in network control and config, which read back as written
   assign rd_mux_w =
      (paddr == ESTI_OFS_NET_CONTROL)  ? net_control_q :
      (paddr == ESTI_OFS_NET_CONFIG)   ? net_config_q :
      (paddr == ESTI_OFS_TYPE_ID)      ? {16'h0000, type_compare_value_q} :
      (paddr == ESTI_OFS_USER_IO)      ? {30'h0000_0000, user_io_q} :
      sel_w[ESTI_CNT_PAUSE]            ? {8'h00, cnt_w[ESTI_CNT_PAUSE]} :
      sel_w[ESTI_CNT_TX_GOOD]          ? {8'h00, cnt_w[ESTI_CNT_TX_GOOD]} :
      sel_w[ESTI_CNT_ONE]              ? {8'h00, cnt_w[ESTI_CNT_ONE]} :
      sel_w[ESTI_CNT_SEVERAL]          ? {8'h00, cnt_w[ESTI_CNT_SEVERAL]} :
      sel_w[ESTI_CNT_RX_GOOD]          ? {8'h00, cnt_w[ESTI_CNT_RX_GOOD]} :
      32'h0000_0000;

   // ------------------------------------------------------------
   // Frame qualification
   // ------------------------------------------------------------
   assign rx_len_ok_w = (rx_frame_len >= ESTI_LEN_MIN) &&
                        (rx_frame_len <= (long_frame_en ? ESTI_LEN_MAX_LONG : ESTI_LEN_MAX));
   assign rx_good_w   = rx_frame_done && rx_len_ok_w && !rx_fcs_err &&
                        !rx_align_err && !rx_symbol_err;
   assign tx_ok_w     = tx_frame_done && !tx_underrun && !tx_retry_limit;

   // Receive events only while receive is enabled
   assign inc_w[ESTI_CNT_PAUSE]   = rx_enable && rx_good_w && rx_is_pause;
   assign inc_w[ESTI_CNT_RX_GOOD] = rx_enable && rx_good_w && rx_addr_match &&
                                    rx_copied_ok;
   assign inc_w[ESTI_CNT_TX_GOOD] = tx_ok_w;
   assign inc_w[ESTI_CNT_ONE]     = tx_ok_w && (tx_collisions == ESTI_COLL_ONE);
   assign inc_w[ESTI_CNT_SEVERAL] = tx_ok_w && (tx_collisions >= ESTI_COLL_SEV_MIN) &&
                                    (tx_collisions <= ESTI_COLL_SEV_MAX);

   // ------------------------------------------------------------
   // Statistics counters
   // ------------------------------------------------------------
   // Cleared at the edge the read data is captured, so no event slips between
   genvar g;
   generate
      for (g = 0; g < ESTI_NUM_CNT; g++)
      begin : g_cnt
         logic [ESTI_CNT_W[g]-1:0] count_w;   // Counter value at its own width

         assign clr_w[g] = rd_setup_w && sel_w[g];
         assign cwr_w[g] = wr_access_w && sel_w[g] && stats_wr_en_w;
         assign cnt_w[g] = ESTI_CNT_MAX_W'(count_w);
         assign cnt_max_w[g] = ESTI_CNT_MAX_W'({ESTI_CNT_W[g]{1'b1}});

         esti_sat_counter #(.W(ESTI_CNT_W[g])) u_cnt
         (
            .clk   (clk),
            .rst   (rst),
            .inc   (inc_w[g]),
            .clr   (clr_w[g]),
            .wr    (cwr_w[g]),
            .wdata (pwdata[ESTI_CNT_W[g]-1:0]),
            .count (count_w)
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   // Software writes take effect in the access phase
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         net_control_q        <= ESTI_RST_NET_CONTROL;
         net_config_q         <= ESTI_RST_NET_CONFIG;
         type_compare_value_q <= ESTI_RST_TYPE_ID;
         user_io_q            <= ESTI_RST_USER_IO;
      end
      else if (wr_access_w)
      begin
         if (paddr == ESTI_OFS_NET_CONTROL)
            net_control_q <= pwdata;
         if (paddr == ESTI_OFS_NET_CONFIG)
            net_config_q <= pwdata;
         if (paddr == ESTI_OFS_TYPE_ID)
            type_compare_value_q <= pwdata[ESTI_TYPE_ID_W-1:0];
         if (paddr == ESTI_OFS_USER_IO)
            user_io_q <= pwdata[1:0];
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge clk)
   begin
      if (rst)
         prdata_q <= 32'h0000_0000;
      else if (rd_setup_w)
         prdata_q <= rd_mux_w;
   end

   // Type field compare, one pulse per received frame that matches
   always_ff @(posedge clk)
   begin
      if (rst)
         type_match_q <= 1'b0;
      else
         type_match_q <= rx_frame_done && (rx_type_len == type_compare_value_q);
   end

   // ------------------------------------------------------------
   // Outputs to the MAC and transceiver
   // ------------------------------------------------------------
   assign type_match        = type_match_q;
   assign rx_enable         = net_control_q[ESTI_BIT_RX_ENABLE];
   assign long_frame_en     = net_config_q[ESTI_BIT_LONG_FRAME];
   assign rmii_mode         = user_io_q[ESTI_BIT_RMII];
   assign phy_clock_gate_on = user_io_q[ESTI_BIT_CLK_GATE];

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_TYPE_MATCH: assert property (
      rx_frame_done && (rx_type_len == type_compare_value_q) |=> type_match)
      else $error("Type match pulse missing");

   AST_RMII_MODE: assert property (
      wr_access_w && (paddr == ESTI_OFS_USER_IO) |=> rmii_mode == $past(pwdata[0]))
      else $error("RMII mode not taken from write");

   AST_CLK_GATE: assert property (
      wr_access_w && (paddr == ESTI_OFS_USER_IO) |=> phy_clock_gate_on == $past(pwdata[1]))
      else $error("Clock gate not taken from write");

   AST_CLEAR_ON_READ: assert property (
      clr_w[ESTI_CNT_TX_GOOD] && !inc_w[ESTI_CNT_TX_GOOD] |=> cnt_w[ESTI_CNT_TX_GOOD] == '0)
      else $error("Counter not cleared by read");

   AST_SATURATE: assert property (
      (cnt_w[ESTI_CNT_TX_GOOD] == cnt_max_w[ESTI_CNT_TX_GOOD]) && !clr_w[ESTI_CNT_TX_GOOD] &&
      !cwr_w[ESTI_CNT_TX_GOOD] |=> cnt_w[ESTI_CNT_TX_GOOD] == cnt_max_w[ESTI_CNT_TX_GOOD])
      else $error("Counter wrapped past all ones");

   AST_RX_GATED: assert property (
      !rx_enable && !clr_w[ESTI_CNT_RX_GOOD] && !cwr_w[ESTI_CNT_RX_GOOD]
      |=> $stable(cnt_w[ESTI_CNT_RX_GOOD]))
      else $error("Receive counter moved with receive disabled");

   AST_WR_GATED: assert property (
      wr_access_w && sel_w[ESTI_CNT_SEVERAL] && !stats_wr_en_w &&
      !inc_w[ESTI_CNT_SEVERAL] |=> $stable(cnt_w[ESTI_CNT_SEVERAL]))
      else $error("Counter written without write enable");

   AST_PAUSE_INC: assert property (
      rx_enable && rx_good_w && rx_is_pause && !clr_w[ESTI_CNT_PAUSE] &&
      !cwr_w[ESTI_CNT_PAUSE] && (cnt_w[ESTI_CNT_PAUSE] < cnt_max_w[ESTI_CNT_PAUSE])
      |=> cnt_w[ESTI_CNT_PAUSE] == $past(cnt_w[ESTI_CNT_PAUSE]) + 24'h000001)
      else $error("Pause counter did not step");

   AST_TX_INC: assert property (
      tx_frame_done && (tx_underrun || tx_retry_limit) && !cwr_w[ESTI_CNT_TX_GOOD] &&
      !clr_w[ESTI_CNT_TX_GOOD] |=> $stable(cnt_w[ESTI_CNT_TX_GOOD]))
      else $error("Failed frame counted as sent");

   AST_ONE_COLL: assert property (
      tx_ok_w && (tx_collisions == 5'd1) && !clr_w[ESTI_CNT_ONE] && !cwr_w[ESTI_CNT_ONE] &&
      (cnt_w[ESTI_CNT_ONE] < cnt_max_w[ESTI_CNT_ONE])
      |=> cnt_w[ESTI_CNT_ONE] == $past(cnt_w[ESTI_CNT_ONE]) + 24'h000001)
      else $error("Single collision frame not counted");

   AST_SEV_COLL: assert property (
      tx_frame_done && ((tx_collisions < 5'd2) || (tx_collisions > 5'd15)) &&
      !clr_w[ESTI_CNT_SEVERAL] && !cwr_w[ESTI_CNT_SEVERAL] |=> $stable(cnt_w[ESTI_CNT_SEVERAL]))
      else $error("Collision count outside 2 to 15 counted");

   AST_RX_GOOD: assert property (
      rx_enable && rx_good_w && rx_addr_match && rx_copied_ok && !clr_w[ESTI_CNT_RX_GOOD] &&
      !cwr_w[ESTI_CNT_RX_GOOD] && (cnt_w[ESTI_CNT_RX_GOOD] < cnt_max_w[ESTI_CNT_RX_GOOD])
      |=> cnt_w[ESTI_CNT_RX_GOOD] == $past(cnt_w[ESTI_CNT_RX_GOOD]) + 24'h000001)
      else $error("Good receive frame not counted");

   AST_CLEAR_KEEPS_EVENT: assert property (
      clr_w[ESTI_CNT_PAUSE] && inc_w[ESTI_CNT_PAUSE] |=> cnt_w[ESTI_CNT_PAUSE] == 24'h000001)
      else $error("Event lost in clearing read");

   COV_READ_CLEAR: cover property (rd_setup_w && sel_w[ESTI_CNT_RX_GOOD] ##1 access_w);
   COV_SATURATED:  cover property (cnt_w[ESTI_CNT_PAUSE] == cnt_max_w[ESTI_CNT_PAUSE]);
   COV_TYPE_MATCH: cover property (type_match);
   COV_UNMAPPED:   cover property (pslverr);

endmodule

/* esti_top_tb.sv */
`timescale 1ns/1ps

module esti_top_tb import esti_pkg::*;;
   logic        clk, rst, psel, penable, pwrite, err;   // Bench drives
   logic [7:0]  paddr;                                  // APB address
   logic [31:0] pwdata, prdata, rd;                     // APB data
   logic        pready, pslverr, type_match, rx_enable, long_frame_en, rmii_mode;
   logic        phy_clock_gate_on, rx_done, rx_pause, tx_done;
   logic [10:0] rx_len;                                 // Model frame fields
   logic [15:0] rx_type, tv;
   logic [2:0]  rx_err;
   logic [1:0]  rx_ok, tx_bad;
   logic [4:0]  tx_coll;
   int          fails, n_tests, i, seed;                // Score
   int          exp_c [ESTI_NUM_CNT];                   // Expected counts
   int          corner [6] = '{63, 64, 1518, 1519, 1536, 1537};

   esti_top esti_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .rx_frame_done(rx_done), .rx_frame_len(rx_len),
      .rx_type_len(rx_type), .rx_fcs_err(rx_err[0]), .rx_align_err(rx_err[1]),
      .rx_symbol_err(rx_err[2]), .rx_is_pause(rx_pause), .rx_addr_match(rx_ok[0]),
      .rx_copied_ok(rx_ok[1]), .tx_frame_done(tx_done), .tx_underrun(tx_bad[0]),
      .tx_retry_limit(tx_bad[1]), .tx_collisions(tx_coll), .type_match(type_match),
      .rx_enable(rx_enable), .long_frame_en(long_frame_en), .rmii_mode(rmii_mode),
      .phy_clock_gate_on(phy_clock_gate_on));
   esti_phy_model esti_phy_model_i (.clk(clk), .rx_done(rx_done), .rx_len(rx_len),
      .rx_type(rx_type), .rx_err(rx_err), .rx_pause(rx_pause), .rx_ok(rx_ok),
      .tx_done(tx_done), .tx_bad(tx_bad), .tx_coll(tx_coll));

   // 100 ns clock
   always #50 clk = ~clk;

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic check(input string w, input logic [31:0] seen, input logic [31:0] ex);
      n_tests++;
      if (seen !== ex)
      begin
         fails++;
         $display("unexpected %s: expected %h seen %h", w, ex, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Saturating increment of an expected count
   function automatic void bump(int k);
      if (exp_c[k] < (1 << ESTI_CNT_W[k]) - 1)
         exp_c[k]++;
   endfunction

   // ------------------------------------------------------------
   // APB master: setup, access held until pready, then release
   // ------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (n == 20)
      begin
         fails++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   // Reads every counter, then expects it cleared
   task automatic read_counters();
      for (int k = 0; k < ESTI_NUM_CNT; k++)
      begin
         apb(1'b0, ESTI_OFS_PAUSE_RX + 8'(4 * k), 32'h0);
         check("counter", rd, 32'(exp_c[k]));
         exp_c[k] = 0;
      end
   endtask

   // One random receive and transmit, with boundary lengths among them
   task automatic frame(input logic en, input logic lng);
      logic [10:0] l;
      logic [15:0] t;
      logic [2:0]  e;
      logic [1:0]  k, b;
      logic        p;
      logic [4:0]  c;
      l = ($urandom_range(2) == 0) ? 11'(corner[$urandom_range(5)]) : 11'($urandom_range(1540));
      t = ($urandom_range(1) == 1) ? tv : 16'($urandom);
      e = ($urandom_range(3) == 0) ? 3'($urandom_range(7, 1)) : 3'h0;
      k = ($urandom_range(3) == 0) ? 2'($urandom) : 2'h3;
      p = 1'($urandom);
      b = ($urandom_range(3) == 0) ? 2'($urandom_range(3, 1)) : 2'h0;
      c = 5'($urandom_range(31));
      fork
         esti_phy_model_i.rx(l, t, e, p, k);
         esti_phy_model_i.tx(b, c);
      join
      #1;
      check("type_match", 32'(type_match), 32'(t == tv));
      if (en && e == 3'h0 && l >= ESTI_LEN_MIN && l <= (lng ? ESTI_LEN_MAX_LONG : ESTI_LEN_MAX))
      begin
         if (p)
            bump(ESTI_CNT_PAUSE);
         if (k == 2'h3)
            bump(ESTI_CNT_RX_GOOD);
      end
      if (b == 2'h0)
      begin
         bump(ESTI_CNT_TX_GOOD);
         if (c == ESTI_COLL_ONE)
            bump(ESTI_CNT_ONE);
         if (c >= ESTI_COLL_SEV_MIN && c <= ESTI_COLL_SEV_MAX)
            bump(ESTI_CNT_SEVERAL);
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {clk, rst, psel, penable, pwrite, paddr, pwdata} = {2'b01, 43'h0};
      exp_c = '{default: 0};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      seed = $urandom(50629);
      // Reset values, then an unmapped address
      for (i = 0; i < 9; i++)
      begin
         apb(1'b0, ESTI_OFS_NET_CONTROL + 8'(4 * i), 32'h0);
         check("reset value", rd, 32'h0);
         check("pslverr", 32'(err), 32'h0);
      end
      apb(1'b0, 8'h24, 32'h0);
      check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
      // Every mode and clock gate combination
      for (i = 0; i < 4; i++)
      begin
         apb(1'b1, ESTI_OFS_USER_IO, 32'(i));
         #1;
         check("rmii_mode", 32'(rmii_mode), 32'(i & 1));
         check("clock gate", 32'(phy_clock_gate_on), 32'(i >> 1));
      end
      tv = 16'($urandom);
      apb(1'b1, ESTI_OFS_TYPE_ID, {16'($urandom), tv});
      apb(1'b0, ESTI_OFS_TYPE_ID, 32'h0);
      check("type value", rd, {16'h0, tv});
      // Receive on, short then long frames, then receive off
      apb(1'b1, ESTI_OFS_NET_CONTROL, 32'h4);
      #1;
      check("rx_enable", 32'(rx_enable), 32'h1);
      repeat (30) frame(1'b1, 1'b0);
      read_counters();
      apb(1'b1, ESTI_OFS_NET_CONFIG, 32'h100);
      #1;
      check("long_frame_en", 32'(long_frame_en), 32'h1);
      repeat (30) frame(1'b1, 1'b1);
      read_counters();
      apb(1'b1, ESTI_OFS_NET_CONTROL, 32'h0);
      #1;
      check("rx_enable", 32'(rx_enable), 32'h0);
      repeat (15) frame(1'b0, 1'b1);
      read_counters();
      // Counter writes refused without the write enable bit
      for (i = 0; i < ESTI_NUM_CNT; i++)
         apb(1'b1, ESTI_OFS_PAUSE_RX + 8'(4 * i), 32'h5);
      read_counters();
      // Preload near the top and run into saturation
      apb(1'b1, ESTI_OFS_NET_CONTROL, 32'h84);
      for (i = 0; i < ESTI_NUM_CNT; i++)
      begin
         exp_c[i] = (1 << ESTI_CNT_W[i]) - 2;
         apb(1'b1, ESTI_OFS_PAUSE_RX + 8'(4 * i), 32'(exp_c[i]));
      end
      repeat (20) frame(1'b1, 1'b1);
      read_counters();
      // Good pause frame on the very edge of a clearing read
      fork
         apb(1'b0, ESTI_OFS_PAUSE_RX, 32'h0);
         esti_phy_model_i.rx(11'd100, 16'h0, 3'h0, 1'b1, 2'h3);
      join
      check("read during event", rd, 32'h0);
      exp_c[ESTI_CNT_PAUSE] = 1;
      exp_c[ESTI_CNT_RX_GOOD] = 1;
      read_counters();
      finish_test();
   end
endmodule
